/* rtl/uart_flow_lin_timer_consts.svh */
// Offsets-free constants: field positions, reset values and timer codes
`ifndef UART_FLOW_LIN_TIMER_CONSTS_SVH
`define UART_FLOW_LIN_TIMER_CONSTS_SVH

// Timer mode codes
`define TMODE_WAIT_TIMEOUT   3'h2
`define TMODE_RX_IDLE        3'h3
`define TMODE_BAUD_DETECT1   3'h5
`define TMODE_BAUD_DETECT2   3'h6
`define TMODE_GENERAL        3'h7

// Flag positions in the status and clear words
`define FLAG_CTS_CHANGE      0
`define FLAG_TIMER_OVERFLOW  1
`define FLAG_BAUD_DONE       2
`define FLAG_BREAK_RECEIVED  3
`define FLAG_FRAMING_ERROR   4

// Frame shape in bit times, and the falling-edge count that ends mode 6
`define FRAME_DATA_BITS      4'h8
`define FRAME_STOP_INDEX     4'h9
`define BAUD_DETECT2_FALLS   3'h4

// Reset values
`define TIMER_RESET_VALUE    24'h00_0000
`define FLAGS_RESET_VALUE    5'h00

`endif

/* rtl/uart_flow_lin_timer_pkg.sv */
// Types shared by the serial extension block and its timer
package uart_flow_lin_timer_pkg;

  // Event flags held by the block
  typedef struct packed {
    logic framing_error_flag;
    logic break_received_flag;
    logic baud_detect_done_flag;
    logic timer_overflow_flag;
    logic cts_change_flag;
  } flags_t;

  // One write to the flag clear register
  typedef struct packed {
    logic   strobe;
    flags_t data;
  } flag_clear_t;

  // One write to the transmit data register
  typedef struct packed {
    logic       strobe;
    logic [7:0] data;
  } tx_write_t;

  typedef enum logic [2:0] {
    TX_IDLE, TX_BREAK, TX_START, TX_DATA, TX_STOP
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE, RX_BITS, RX_WAIT_HIGH
  } rx_state_t;

endpackage : uart_flow_lin_timer_pkg

/* rtl/uart_lin_timer.sv */
// Built-in 24-bit timer with timeout, idle and bit-rate measuring modes
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_lin_timer_consts.svh"
module uart_lin_timer import uart_flow_lin_timer_pkg::*; #(
  parameter int WIDTH = 24
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic [2:0]       timer_mode_select,
  input  wire logic             mode_write,
  input  wire logic [WIDTH-1:0] timer_reload_value,
  input  wire logic             count_clock_en,
  input  wire logic             baud_en,
  input  wire logic             rx_fall,
  input  wire logic             rx_rise,
  input  wire logic             rx_stop_bit,
  output logic [WIDTH-1:0]      timer_count,
  output logic                  overflow_pulse,
  output logic                  done_pulse
);

  logic       run_r;
  logic [2:0] falls_r;
  logic       tick;
  logic       hit;

  // Baud-clocked modes count bit times, the rest count the count clock
  always_comb begin
    tick = (timer_mode_select == `TMODE_WAIT_TIMEOUT ||
            timer_mode_select == `TMODE_RX_IDLE) ? baud_en : count_clock_en;
    hit  = run_r && tick && (timer_count == timer_reload_value);
  end

  // Run control, counter and events per mode
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_r          <= 1'b0;
      falls_r        <= 3'h0;
      timer_count    <= `TIMER_RESET_VALUE;
      overflow_pulse <= 1'b0;
      done_pulse     <= 1'b0;
    end else begin
      overflow_pulse <= 1'b0;
      done_pulse     <= 1'b0;
      if (mode_write) begin
        timer_count <= `TIMER_RESET_VALUE;
        falls_r     <= 3'h0;
        // Timeout and general modes start at once
        run_r <= (timer_mode_select == `TMODE_WAIT_TIMEOUT ||
                  timer_mode_select == `TMODE_GENERAL);
      end else begin
        case (timer_mode_select)
          `TMODE_WAIT_TIMEOUT, `TMODE_RX_IDLE: begin
            if (rx_stop_bit) begin
              run_r       <= 1'b1;
              timer_count <= `TIMER_RESET_VALUE;
            end else if (hit) begin
              run_r          <= 1'b0;
              overflow_pulse <= 1'b1;
            end else if (run_r && tick) begin
              timer_count <= timer_count + 1'b1;
            end
          end
          `TMODE_BAUD_DETECT1, `TMODE_BAUD_DETECT2: begin
            if (!run_r && rx_fall && falls_r == 3'h0) begin
              run_r       <= 1'b1;
              falls_r     <= 3'h1;
              timer_count <= `TIMER_RESET_VALUE;
            end else if (run_r &&
                         ((timer_mode_select == `TMODE_BAUD_DETECT1 &&
                           rx_rise) ||
                          (timer_mode_select == `TMODE_BAUD_DETECT2 &&
                           rx_fall &&
                           falls_r == `BAUD_DETECT2_FALLS - 3'h1))) begin
              run_r      <= 1'b0;
              falls_r    <= `BAUD_DETECT2_FALLS;
              done_pulse <= 1'b1;
            end else begin
              if (run_r && rx_fall) begin
                falls_r <= falls_r + 3'h1;
              end
              if (hit) begin
                // Wrap and keep counting so long edges still measure
                overflow_pulse <= 1'b1;
                timer_count    <= `TIMER_RESET_VALUE;
              end else if (run_r && tick) begin
                timer_count <= timer_count + 1'b1;
              end
            end
          end
          `TMODE_GENERAL: begin
            if (hit) begin
              run_r          <= 1'b0;
              overflow_pulse <= 1'b1;
            end else if (run_r && tick) begin
              timer_count <= timer_count + 1'b1;
            end
          end
          default: begin
            run_r <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : uart_lin_timer
`default_nettype wire

/* rtl/uart_flow_lin_timer.sv */
// Serial port extension: clear-to-send gating, LIN break and sync, timer
// Summary of operation
// - Send next frame when CTS low, idle
// - CTS high finishes frame then holds off
// - Status bit mirrors CTS pin level
// - CTS change sets flag, interrupt when enabled
// - Writing zero clears the CTS change flag
// - Byte field: start, eight LSB-first, stop
// - Break write drives low count bits, clears
// - Writing 0x55 sends the sync byte
// - LIN mode enables break detection with threshold
// - Long low plus delimiter sets break flag
// - Early high cancels break detection
// - Framing error stalls receiver until high
// - Framing error also set; software clears both
// - Timer is 24-bit counter plus reload
// - Mode field selects five timer modes
// - Mode 2: wait timeout on baud clock
// - Mode 3: receive idle after stop bit
// - Mode 5: low pulse width on count clock
// - Mode 6: measure until fourth falling edge
// - Mode 7 starts at once, stops itself
// - Writing zero clears timer and break flags
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_lin_timer_consts.svh"
module uart_flow_lin_timer import uart_flow_lin_timer_pkg::*; #(
  parameter int TIMER_WIDTH = 24,
  parameter int BRK_WIDTH   = 8
) (
  input  wire logic                   sys_clk,
  input  wire logic                   arst_n,
  input  wire logic                   count_clock_en,
  input  wire logic                   baud_en,
  input  wire logic                   cts_n,
  input  wire logic                   receive_pin,
  output logic                        transmit_pin,
  input  wire logic                   clear_to_send_gate_enable,
  input  wire logic                   lin_mode,
  input  wire logic                   send_break_set,
  output logic                        send_break_request,
  input  wire logic [BRK_WIDTH-1:0]   break_length_threshold,
  input  wire tx_write_t              transmit_data_register,
  output logic                        transmit_buffer_empty,
  output logic                        transmit_busy,
  output logic [7:0]                  receive_data_register,
  input  wire logic [2:0]             timer_mode_select,
  input  wire logic                   timer_mode_write,
  input  wire logic [TIMER_WIDTH-1:0] timer_reload_value,
  output logic [TIMER_WIDTH-1:0]      timer_count,
  output logic                        cts_pin_level,
  output flags_t                      flag_status_register,
  input  wire flags_t                 interrupt_enable_register,
  input  wire flag_clear_t            flag_clear_register,
  output logic                        irq_request
);

  // Synchroniser stages; first stage is read only by the second
  logic cts_meta_r;
  logic cts_sync_r;
  logic cts_prev_r;
  logic rx_meta_r;
  logic rx_sync_r;
  logic rx_prev_r;

  // Transmit path
  tx_state_t      tx_state_r;
  logic [7:0]     tx_buf_r;
  logic           tx_full_r;
  logic [7:0]     tx_shift_r;
  logic [3:0]     tx_bit_r;
  logic [7:0]     brk_left_r;

  // Receive break detector
  rx_state_t      rx_state_r;
  logic [3:0]     rx_bit_r;
  logic [7:0]     rx_data_r;
  logic           all_low_r;
  logic [BRK_WIDTH-1:0] low_run_r;

  // Events raised this cycle
  logic rx_fall;
  logic rx_rise;
  logic cts_change;
  logic rx_stop_bit;
  logic frame_error;
  logic break_seen;
  logic timer_ovf;
  logic baud_done;
  logic cts_allows;
  logic brk_write;

  // Saturating increment shared by the low-run counter paths
  function automatic logic [BRK_WIDTH-1:0] sat_inc(
    input logic [BRK_WIDTH-1:0] v
  );
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction : sat_inc

  // Flag update: a set in the same cycle as a clear wins
  function automatic logic next_flag(
    input logic cur,
    input logic set,
    input logic clr
  );
    next_flag = set | (cur & ~clr);
  endfunction : next_flag

  // Two-stage synchronisers for both pins
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cts_meta_r <= 1'b1;
      cts_sync_r <= 1'b1;
      cts_prev_r <= 1'b1;
      rx_meta_r  <= 1'b1;
      rx_sync_r  <= 1'b1;
      rx_prev_r  <= 1'b1;
    end else begin
      cts_meta_r <= cts_n;
      cts_sync_r <= cts_meta_r;
      cts_prev_r <= cts_sync_r;
      rx_meta_r  <= receive_pin;
      rx_sync_r  <= rx_meta_r;
      rx_prev_r  <= rx_sync_r;
    end
  end

  // Edge and level detection only on synchronised copies
  always_comb begin
    rx_fall    = rx_prev_r & ~rx_sync_r;
    rx_rise    = ~rx_prev_r & rx_sync_r;
    cts_change = cts_prev_r ^ cts_sync_r;
    cts_allows = ~clear_to_send_gate_enable | ~cts_sync_r;
    brk_write  = transmit_data_register.strobe & lin_mode &
                 send_break_request;
  end

  assign cts_pin_level         = cts_sync_r;
  assign transmit_buffer_empty = ~tx_full_r;
  assign transmit_busy         = (tx_state_r != TX_IDLE);

  // Holding buffer; a break-length write bypasses it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buf_r  <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (transmit_data_register.strobe && !brk_write) begin
      tx_buf_r  <= transmit_data_register.data;
      tx_full_r <= 1'b1;
    end else if (tx_state_r == TX_IDLE && tx_full_r && cts_allows) begin
      tx_full_r <= 1'b0;
    end
  end

  // Send-break request: software sets it, end of break clears it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      send_break_request <= 1'b0;
    end else if (send_break_set) begin
      send_break_request <= 1'b1;
    end else if (tx_state_r == TX_BREAK && baud_en &&
                 brk_left_r <= 8'h01) begin
      send_break_request <= 1'b0;
    end
  end

  // Transmit sequencer, one bit per baud enable
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state_r   <= TX_IDLE;
      tx_shift_r   <= 8'h00;
      tx_bit_r     <= 4'h0;
      brk_left_r   <= 8'h00;
      transmit_pin <= 1'b1;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          transmit_pin <= 1'b1;
          if (brk_write) begin
            // Dominant level starts at once, not on a bit boundary
            brk_left_r   <= transmit_data_register.data;
            transmit_pin <= 1'b0;
            tx_state_r   <= TX_BREAK;
          end else if (tx_full_r && cts_allows) begin
            // A high CTS only blocks here, never mid-frame
            tx_shift_r <= tx_buf_r;
            tx_state_r <= TX_START;
          end
        end
        TX_BREAK: begin
          if (baud_en) begin
            brk_left_r <= brk_left_r - 8'h01;
            if (brk_left_r <= 8'h01) begin
              transmit_pin <= 1'b1;
              tx_state_r   <= TX_IDLE;
            end
          end
        end
        TX_START: begin
          if (baud_en) begin
            transmit_pin <= 1'b0;
            tx_bit_r     <= 4'h0;
            tx_state_r   <= TX_DATA;
          end
        end
        TX_DATA: begin
          if (baud_en) begin
            transmit_pin <= tx_shift_r[0];
            tx_shift_r   <= {1'b0, tx_shift_r[7:1]};
            tx_bit_r     <= tx_bit_r + 4'h1;
            if (tx_bit_r == `FRAME_DATA_BITS - 4'h1) begin
              tx_state_r <= TX_STOP;
            end
          end
        end
        TX_STOP: begin
          if (baud_en) begin
            transmit_pin <= 1'b1;
            tx_state_r   <= TX_IDLE;
          end
        end
        default: begin
          tx_state_r <= TX_IDLE;
        end
      endcase
    end
  end

  // Receive detector: frame sampling and break search
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state_r            <= RX_IDLE;
      rx_bit_r              <= 4'h0;
      rx_data_r             <= 8'h00;
      all_low_r             <= 1'b0;
      low_run_r             <= '0;
      rx_stop_bit           <= 1'b0;
      frame_error           <= 1'b0;
      break_seen            <= 1'b0;
      receive_data_register <= 8'h00;
    end else begin
      rx_stop_bit <= 1'b0;
      frame_error <= 1'b0;
      break_seen  <= 1'b0;
      case (rx_state_r)
        RX_IDLE: begin
          if (rx_fall) begin
            rx_state_r <= RX_BITS;
            rx_bit_r   <= 4'h0;
            all_low_r  <= 1'b1;
            low_run_r  <= '0;
          end
        end
        RX_BITS: begin
          if (baud_en) begin
            rx_bit_r <= rx_bit_r + 4'h1;
            if (rx_sync_r) begin
              all_low_r <= 1'b0;
            end else if (all_low_r) begin
              low_run_r <= sat_inc(low_run_r);
            end
            if (rx_bit_r != 4'h0 && rx_bit_r != `FRAME_STOP_INDEX) begin
              rx_data_r <= {rx_sync_r, rx_data_r[7:1]};
            end
            if (rx_bit_r == `FRAME_STOP_INDEX) begin
              receive_data_register <= rx_data_r;
              if (rx_sync_r) begin
                rx_stop_bit <= 1'b1;
                rx_state_r  <= RX_IDLE;
              end else begin
                // Receiver stalls until the line returns high
                frame_error <= 1'b1;
                rx_state_r  <= RX_WAIT_HIGH;
              end
            end
          end
        end
        RX_WAIT_HIGH: begin
          if (baud_en) begin
            if (rx_sync_r) begin
              // Delimiter after a long enough low is a break
              break_seen <= lin_mode && all_low_r &&
                            (low_run_r >= break_length_threshold);
              rx_state_r <= RX_IDLE;
            end else if (all_low_r) begin
              low_run_r <= sat_inc(low_run_r);
            end
          end
        end
        default: begin
          rx_state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // Built-in timer
  uart_lin_timer #(
    .WIDTH (TIMER_WIDTH)
  ) u_timer (
    .sys_clk            (sys_clk),
    .arst_n             (arst_n),
    .timer_mode_select  (timer_mode_select),
    .mode_write         (timer_mode_write),
    .timer_reload_value (timer_reload_value),
    .count_clock_en     (count_clock_en),
    .baud_en            (baud_en),
    .rx_fall            (rx_fall),
    .rx_rise            (rx_rise),
    .rx_stop_bit        (rx_stop_bit),
    .timer_count        (timer_count),
    .overflow_pulse     (timer_ovf),
    .done_pulse         (baud_done)
  );

  // Sticky flags; clearing is by writing zero to the bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_status_register <= `FLAGS_RESET_VALUE;
    end else begin
      flag_status_register.cts_change_flag <= next_flag(
        flag_status_register.cts_change_flag, cts_change,
        flag_clear_register.strobe &
        ~flag_clear_register.data.cts_change_flag);
      flag_status_register.timer_overflow_flag <= next_flag(
        flag_status_register.timer_overflow_flag, timer_ovf,
        flag_clear_register.strobe &
        ~flag_clear_register.data.timer_overflow_flag);
      flag_status_register.baud_detect_done_flag <= next_flag(
        flag_status_register.baud_detect_done_flag, baud_done,
        flag_clear_register.strobe &
        ~flag_clear_register.data.baud_detect_done_flag);
      flag_status_register.break_received_flag <= next_flag(
        flag_status_register.break_received_flag, break_seen,
        flag_clear_register.strobe &
        ~flag_clear_register.data.break_received_flag);
      flag_status_register.framing_error_flag <= next_flag(
        flag_status_register.framing_error_flag, frame_error,
        flag_clear_register.strobe &
        ~flag_clear_register.data.framing_error_flag);
    end
  end

  // Enabled flags request service
  assign irq_request = |(flag_status_register &
                         interrupt_enable_register);

endmodule : uart_flow_lin_timer
`default_nettype wire

/* verification/uart_flow_lin_timer_checker.sv */
// Port-level assertions for the serial extension block
`timescale 1ns/100ps
`default_nettype none
module uart_flow_lin_timer_checker import uart_flow_lin_timer_pkg::*; #(
  parameter int TIMER_WIDTH = 24
) (
  input wire logic                   sys_clk,
  input wire logic                   arst_n,
  input wire logic                   cts_n,
  input wire logic                   transmit_pin,
  input wire logic                   clear_to_send_gate_enable,
  input wire logic                   lin_mode,
  input wire logic                   send_break_request,
  input wire tx_write_t              transmit_data_register,
  input wire logic                   transmit_busy,
  input wire logic [2:0]             timer_mode_select,
  input wire logic                   timer_mode_write,
  input wire logic [TIMER_WIDTH-1:0] timer_count,
  input wire logic                   cts_pin_level,
  input wire flags_t                 flag_status_register,
  input wire flags_t                 interrupt_enable_register,
  input wire logic                   irq_request
);
  // Single clock domain, so one default clock and reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  idle_pin_high_a: assert property (
    !transmit_busy |-> transmit_pin) else $error("line low while idle");
  // Six stable samples cover the synchroniser and status register
  cts_level_a: assert property (
    $stable(cts_n) [*6] |-> cts_pin_level == cts_n)
    else $error("cts level bit wrong");
  cts_flag_a: assert property (
    $changed(cts_pin_level) |-> ##[0:2] flag_status_register.cts_change_flag)
    else $error("cts change flag missing");
  irq_map_a: assert property (
    irq_request == |(flag_status_register & interrupt_enable_register))
    else $error("irq does not match flags");
  break_end_a: assert property (
    $fell(send_break_request) |-> transmit_pin && !$past(transmit_pin))
    else $error("break request cleared off the break end");
  break_start_a: assert property (
    lin_mode && send_break_request && transmit_data_register.strobe &&
    !transmit_busy |=> !transmit_pin) else $error("break did not start");
  timer_stop_a: assert property (
    $rose(flag_status_register.timer_overflow_flag) &&
    timer_mode_select inside {3'h2, 3'h7} |=> $stable(timer_count) [*3])
    else $error("timer kept counting after overflow");
  mode_zero_a: assert property (
    timer_mode_write |=> timer_count == '0) else $error("count not zeroed");
  cts_gate_a: assert property (
    (clear_to_send_gate_enable && cts_n) [*5] ##0
    (!transmit_busy && !send_break_request) |=> !transmit_busy)
    else $error("frame started while cts high");
endmodule : uart_flow_lin_timer_checker

bind uart_flow_lin_timer uart_flow_lin_timer_checker #(
  .TIMER_WIDTH(TIMER_WIDTH)
) chk (
  .sys_clk, .arst_n, .cts_n, .transmit_pin, .clear_to_send_gate_enable,
  .lin_mode, .send_break_request, .transmit_data_register, .transmit_busy,
  .timer_mode_select, .timer_mode_write, .timer_count, .cts_pin_level,
  .flag_status_register, .interrupt_enable_register, .irq_request
);
`default_nettype wire

/* verification/remote_node.sv */
// Remote serial node: drives the receive line and clear-to-send pin
`timescale 1ns/100ps
`default_nettype none
module remote_node (
  input  wire logic sys_clk,
  input  wire logic baud_en,
  output var logic  receive_pin,
  output var logic  cts_n
);
  // Line idles high; cts starts inactive to match the reset level
  initial begin
    receive_pin = 1'b1;
    cts_n       = 1'b1;
  end
  task automatic set_cts(input logic v);
    cts_n = v;
  endtask : set_cts
  // Bits change just after a tick so the block samples mid-bit
  task automatic hold_line(input logic lvl, input int n);
    receive_pin = lvl;
    repeat (n) @(posedge sys_clk iff baud_en);
    #1;
  endtask : hold_line
  task automatic send_byte(input logic [7:0] b, input logic stop);
    @(posedge sys_clk iff baud_en);
    #1;
    hold_line(1'b0, 1);
    for (int i = 0; i < 8; i++)
      hold_line(b[i], 1);
    hold_line(stop, 1);
  endtask : send_byte
  // Dominant low run followed by a one-bit delimiter
  task automatic send_low(input int n);
    @(posedge sys_clk iff baud_en);
    #1;
    hold_line(1'b0, n);
    hold_line(1'b1, 1);
  endtask : send_low
endmodule : remote_node
`default_nettype wire

/* verification/test_uart_flow_lin_timer.sv */
// Self-checking bench for the serial extension block
`timescale 1ns/100ps
`default_nettype none
`include "uart_flow_lin_timer_consts.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_uart_flow_lin_timer import uart_flow_lin_timer_pkg::*; ;
  logic        sys_clk, arst_n, count_clock_en, baud_en, cts_n, gate;
  logic        receive_pin, transmit_pin, lin_mode, send_break_set;
  logic        send_break_request, transmit_buffer_empty, transmit_busy;
  logic        timer_mode_write, cts_pin_level, irq_request;
  logic [7:0]  brk_len, receive_data_register;
  logic [2:0]  timer_mode_select;
  logic [23:0] timer_reload_value, timer_count;
  logic [1:0]  phase;
  logic [2:0]  dead [3];
  tx_write_t   txw;
  flags_t      fl, ien;
  flag_clear_t fcl;
  int          fail_count, num_checks, cycles, k;

  uart_flow_lin_timer uut (
    .sys_clk, .arst_n, .count_clock_en, .baud_en, .cts_n, .receive_pin,
    .transmit_pin, .clear_to_send_gate_enable(gate), .lin_mode,
    .send_break_set, .send_break_request, .break_length_threshold(brk_len),
    .transmit_data_register(txw), .transmit_buffer_empty, .transmit_busy,
    .receive_data_register, .timer_mode_select, .timer_mode_write,
    .timer_reload_value, .timer_count, .cts_pin_level,
    .flag_status_register(fl), .interrupt_enable_register(ien),
    .flag_clear_register(fcl), .irq_request
  );
  remote_node peer (.sys_clk, .baud_en, .receive_pin, .cts_n);

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Bit tick every fourth cycle, count tick every second one
  always @(posedge sys_clk) begin
    #1;
    phase <= phase + 2'h1;
  end
  assign baud_en        = (phase == 2'h0);
  assign count_clock_en = phase[0];
  // Cut a hang short; the full run needs well under this many cycles
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic wr_tx(input logic [7:0] b);
    txw = '{1'b1, b};
    cyc(1);
    txw.strobe = 1'b0;
  endtask : wr_tx
  // A zero in the written word clears that flag
  task automatic clr(input flags_t m);
    fcl = '{1'b1, ~m};
    cyc(1);
    fcl.strobe = 1'b0;
  endtask : clr
  task automatic set_mode(input logic [2:0] m, input logic [23:0] r);
    timer_mode_select  = m;
    timer_reload_value = r;
    timer_mode_write   = 1'b1;
    cyc(1);
    timer_mode_write = 1'b0;
  endtask : set_mode
  // Waits for the start bit, then samples every bit at its middle
  task automatic expect_frame(input logic [7:0] b);
    logic [9:0] bits;
    bits = {1'b1, b, 1'b0};
    for (k = 0; k < 400 && transmit_pin === 1'b1; k++)
      cyc(1);
    cyc(2);
    for (int i = 0; i < 10; i++) begin
      `CHK(transmit_pin, bits[i])
      cyc(4);
    end
  endtask : expect_frame

  initial begin
    {arst_n, gate, lin_mode, send_break_set, timer_mode_write} = 5'h00;
    {phase, cycles, fail_count, num_checks} = '0;
    brk_len            = 8'h0B;
    timer_mode_select  = 3'h0;
    timer_reload_value = 24'h00_0000;
    txw  = '{1'b0, 8'h00};
    fcl  = '{1'b0, 5'h00};
    ien  = 5'h01;
    dead = '{3'h0, 3'h1, 3'h4};
    cyc(10);
    arst_n = 1'b1;
    `CHK(fl, `FLAGS_RESET_VALUE)
    `CHK(timer_count, `TIMER_RESET_VALUE)
    // Clear-to-send: frame in flight finishes, next waits for cts low
    gate = 1'b1;
    peer.set_cts(1'b0);
    cyc(6);
    `CHK(fl.cts_change_flag, 1'b1)
    clr(5'h1F);
    wr_tx(8'hA3);
    fork
      expect_frame(8'hA3);
      begin
        cyc(16);
        peer.set_cts(1'b1);
      end
    join
    `CHK(cts_pin_level, 1'b1)
    `CHK(irq_request, 1'b1)
    wr_tx(8'h5A);
    cyc(60);
    `CHK(transmit_pin, 1'b1)
    `CHK(transmit_buffer_empty, 1'b0)
    clr(5'h01);
    `CHK(fl.cts_change_flag, 1'b0)
    peer.set_cts(1'b0);
    expect_frame(8'h5A);
    `CHK(cts_pin_level, 1'b0)
    // Break of thirteen bit times, then the sync byte
    gate = 1'b0;
    lin_mode = 1'b1;
    send_break_set = 1'b1;
    cyc(1);
    send_break_set = 1'b0;
    `CHK(send_break_request, 1'b1)
    wr_tx(8'h0D);
    `CHK(transmit_pin, 1'b0)
    for (k = 0; k < 100 && transmit_pin === 1'b0; k++)
      cyc(1);
    `CHK(k >= 48 && k <= 53, 1'b1)
    `CHK(send_break_request, 1'b0)
    wr_tx(8'h55);
    expect_frame(8'h55);
    // Identifier 0x3C carries two zero parity bits
    wr_tx(8'h3C);
    expect_frame(8'h3C);
    // Received break above threshold, then a low run cut short
    peer.send_low(13);
    cyc(8);
    `CHK(fl.break_received_flag, 1'b1)
    `CHK(fl.framing_error_flag, 1'b1)
    `CHK(receive_data_register, 8'h00)
    clr(5'h18);
    `CHK(fl, 5'h01)
    peer.send_byte(8'hF0, 1'b0);
    peer.hold_line(1'b0, 2);
    peer.hold_line(1'b1, 2);
    `CHK(fl.break_received_flag, 1'b0)
    `CHK(fl.framing_error_flag, 1'b1)
    clr(5'h1F);
    // General timer counts count ticks up to reload and stops
    set_mode(`TMODE_GENERAL, 24'h00_0010);
    cyc(20);
    `CHK(fl.timer_overflow_flag, 1'b0)
    cyc(24);
    `CHK(fl.timer_overflow_flag, 1'b1)
    `CHK(timer_count, 24'h00_0010)
    clr(5'h1F);
    foreach (dead[i]) begin
      set_mode(dead[i], 24'h00_0003);
      cyc(20);
      `CHK(timer_count, `TIMER_RESET_VALUE)
      `CHK(fl.timer_overflow_flag, 1'b0)
    end
    set_mode(`TMODE_WAIT_TIMEOUT, 24'h00_0005);
    cyc(12);
    `CHK(fl.timer_overflow_flag, 1'b0)
    cyc(16);
    `CHK(fl.timer_overflow_flag, 1'b1)
    `CHK(timer_count, 24'h00_0005)
    clr(5'h1F);
    set_mode(`TMODE_RX_IDLE, 24'h00_0003);
    cyc(20);
    `CHK(timer_count, `TIMER_RESET_VALUE)
    peer.send_byte(8'h3C, 1'b1);
    cyc(3);
    `CHK(receive_data_register, 8'h3C)
    cyc(20);
    `CHK(fl.timer_overflow_flag, 1'b1)
    // Bit-rate measurement: low pulse width, then a sync byte
    clr(5'h1F);
    set_mode(`TMODE_BAUD_DETECT1, 24'h00_0003);
    peer.send_low(3);
    cyc(4);
    `CHK(fl.baud_detect_done_flag, 1'b1)
    `CHK(fl.timer_overflow_flag, 1'b1)
    clr(5'h1F);
    set_mode(`TMODE_BAUD_DETECT2, 24'h00_FFFF);
    peer.send_byte(8'h55, 1'b1);
    `CHK(fl.baud_detect_done_flag, 1'b1)
    k = timer_count;
    `CHK(k >= 10 && k <= 18, 1'b1)
    clr(5'h1F);
    `CHK(fl, `FLAGS_RESET_VALUE)
    close_out();
  end
endmodule : test_uart_flow_lin_timer
`default_nettype wire
